// >>> hw/hpi_pkg.sv
package hpi_pkg;
  localparam int             DATA_W        = 8;
  localparam int             ADDR_W        = 8;
  localparam int             NUM_CMD       = 16;
  localparam int             IRQ_W         = 8;
  localparam logic [7:0]     CMD_DEF       = 8'h00;
  localparam logic [7:0]     IRQ_EN_DEF    = 8'h00;
  localparam logic [7:0]     IRQ_STAT_DEF  = 8'h00;
  localparam logic [7:0]     RD_UNMAPPED   = 8'h00;
  // Command registers sit at 0x00 upward, one byte each
  localparam logic [7:0]     CMD_BASE      = 8'h00;
  localparam logic [7:0]     IRQ_EN_ADDR   = 8'h20;
  localparam logic [7:0]     IRQ_STAT_ADDR = 8'h21;
endpackage

// >>> hw/hpi_if.sv
interface hpi_if;
  logic       wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       hit;
  modport port (output wr_en, output addr, output wdata, input rdata, input hit);
  modport regs (input wr_en, input addr, input wdata, output rdata, output hit);
endinterface

// >>> hw/cmd_regs.sv
module cmd_regs #(
  parameter int N = hpi_pkg::NUM_CMD
) (
  input  wire logic           clk_sys,
  input  wire logic           rst,
  hpi_if.regs                 bus,
  output logic [N*8-1:0]      cfg
);

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < N; i++) begin : g_reg
    logic [7:0] q_r;
    logic [7:0] q_nxt;
    always_comb begin
      q_nxt = q_r;
      if (bus.wr_en && bus.addr == 8'(i) + hpi_pkg::CMD_BASE) begin
        q_nxt = bus.wdata;
      end
    end
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        q_r <= hpi_pkg::CMD_DEF;
      end else begin
        q_r <= q_nxt;
      end
    end
    assign cfg[i*8 +: 8] = q_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // index selects register
  always_comb begin
    bus.rdata = hpi_pkg::RD_UNMAPPED;
    bus.hit   = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (bus.addr == 8'(i) + hpi_pkg::CMD_BASE) begin
        bus.rdata = cfg[i*8 +: 8];
        bus.hit   = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_wr_store;
    @(posedge clk_sys) disable iff (rst)
    (bus.wr_en && bus.addr < 8'(N))
      |=> cfg[$past(bus.addr)*8 +: 8] == $past(bus.wdata);
  endproperty
  chk_write_stores_cmd: assert property (p_wr_store)
    else $error("command register did not take written byte");

endmodule

// >>> hw/host_register_port.sv
// What this block does
// - Eight-bit index selects the accessed register
// - Data bus driven out only during reads
// - Interrupt high normally, low on enabled event
// - Reading status clears it; interrupt then releases
// - Reset low returns command registers to defaults
// - Undriven reset reads high; hold high normally
// - Write strobe stores data at indexed register
// - Read strobe returns indexed register contents
// - Ready low marks the access as completed
module host_register_port #(
  parameter int NUM_CMD = hpi_pkg::NUM_CMD,
  parameter int IRQ_W   = hpi_pkg::IRQ_W
) (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 reset_pin_n,
  input  wire logic                 cs_n,
  input  wire logic                 wr_n,
  input  wire logic                 rd_n,
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           data_in,
  output logic      [7:0]           data_out,
  output logic                      data_oe,
  output logic                      rdy_n,
  output logic                      int_n,
  input  wire logic [IRQ_W-1:0]     irq_event,
  output logic      [NUM_CMD*8-1:0] cfg_out
);

  typedef enum logic {ST_IDLE, ST_ACK} state_e;

  logic             rst;
  logic             req_wr;
  logic             req_rd;
  logic             take;
  logic             done;
  logic [7:0]       rdata;
  state_e           state_r;
  state_e           state_nxt;
  logic             oe_r;
  logic             oe_nxt;
  logic [7:0]       dout_r;
  logic [7:0]       dout_nxt;
  logic [IRQ_W-1:0] en_r;
  logic [IRQ_W-1:0] en_nxt;
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] stat_nxt;
  logic [IRQ_W-1:0] stat_clr;

  hpi_if bus_if ();

  ////////////////////////////////////////////////////////////////////////////
  // pin reset joins system reset
  // pin must idle high; low means reset
  assign rst = srst | ~reset_pin_n;

  // nothing happens without chip select
  // Both strobes low together is ambiguous, so it is ignored
  assign req_wr = ~cs_n & ~wr_n & rd_n;
  assign req_rd = ~cs_n & ~rd_n & wr_n;
  assign take   = (state_r == ST_IDLE) & (req_wr | req_rd);
  assign done   = cs_n | (wr_n & rd_n);

  assign bus_if.wr_en = take & req_wr;
  assign bus_if.addr  = addr;
  assign bus_if.wdata = data_in;

  cmd_regs #(
    .N       (NUM_CMD)
  ) u_cmd_regs (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (bus_if.regs),
    .cfg     (cfg_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read decode by index
  always_comb begin
    rdata = hpi_pkg::RD_UNMAPPED;
    if (addr == hpi_pkg::IRQ_EN_ADDR) begin
      rdata = 8'(en_r);
    end else if (addr == hpi_pkg::IRQ_STAT_ADDR) begin
      rdata = 8'(stat_r);
    end else if (bus_if.hit) begin
      rdata = bus_if.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer: ready stays low until the host drops its strobe
  always_comb begin
    state_nxt = state_r;
    oe_nxt    = oe_r;
    dout_nxt  = dout_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          state_nxt = ST_ACK;
          oe_nxt    = req_rd;
          if (req_rd) begin
            dout_nxt = rdata;
          end
        end
      end
      ST_ACK: begin
        if (done) begin
          state_nxt = ST_IDLE;
          oe_nxt    = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        oe_nxt    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_IDLE;
      oe_r    <= 1'b0;
      dout_r  <= hpi_pkg::RD_UNMAPPED;
    end else begin
      state_r <= state_nxt;
      oe_r    <= oe_nxt;
      dout_r  <= dout_nxt;
    end
  end

  assign rdy_n    = (state_r != ST_ACK);
  assign data_oe  = oe_r;
  assign data_out = dout_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable and sticky status
  // read of status clears captured bits
  assign stat_clr = (take && req_rd && addr == hpi_pkg::IRQ_STAT_ADDR) ? stat_r : '0;

  always_comb begin
    en_nxt = en_r;
    if (bus_if.wr_en && addr == hpi_pkg::IRQ_EN_ADDR) begin
      en_nxt = IRQ_W'(data_in);
    end
    // An event in the clearing cycle survives the clear
    stat_nxt = (stat_r & ~stat_clr) | irq_event;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_r   <= IRQ_W'(hpi_pkg::IRQ_EN_DEF);
      stat_r <= IRQ_W'(hpi_pkg::IRQ_STAT_DEF);
    end else begin
      en_r   <= en_nxt;
      stat_r <= stat_nxt;
    end
  end

  // stays low until host reads status or an enable write masks the set bits
  assign int_n = ~|(stat_r & en_r);

  ////////////////////////////////////////////////////////////////////////////
  sequence s_take_rd;
    take && req_rd;
  endsequence

  sequence s_take_wr;
    take && req_wr;
  endsequence

  sequence s_stat_rd;
    take && req_rd && addr == hpi_pkg::IRQ_STAT_ADDR;
  endsequence

  // Only a status read or an enable write may release a pending interrupt
  chk_int_held_low: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!int_n && !bus_if.wr_en && !(take && req_rd && addr == hpi_pkg::IRQ_STAT_ADDR))
      |=> !int_n)
    else $error("interrupt released before status read");

  chk_event_raises_int: assert property (
    @(posedge clk_sys) disable iff (rst)
    (|(irq_event & en_r) && !bus_if.wr_en) |=> !int_n)
    else $error("enabled event did not pull interrupt low");

  chk_status_read_clears: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_stat_rd |=> stat_r == $past(irq_event))
    else $error("status read did not clear flags");

  chk_set_beats_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    |irq_event |=> (stat_r & $past(irq_event)) == $past(irq_event))
    else $error("event lost against clear");

  chk_reset_defaults: assert property (
    @(posedge clk_sys)
    rst |=> en_r == '0 && stat_r == '0 && rdy_n && !data_oe)
    else $error("reset did not restore defaults");

  chk_ready_after_take: assert property (
    @(posedge clk_sys) disable iff (rst)
    take |=> !rdy_n ##0 (state_r == ST_ACK))
    else $error("ready not asserted after access");

  chk_ready_holds: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!rdy_n && !done) |=> !rdy_n)
    else $error("ready released before strobe ended");

  chk_ready_releases: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!rdy_n && done) |=> rdy_n)
    else $error("ready held after strobe ended");

  chk_read_drives_data: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_take_rd |=> data_oe && data_out == $past(rdata))
    else $error("read did not return indexed contents");

  chk_write_no_drive: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_take_wr |=> !data_oe [*1] ##0 !rdy_n)
    else $error("data bus driven during write");

  chk_idle_no_drive: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cs_n && state_r == ST_IDLE) |=> !data_oe && rdy_n)
    else $error("activity without chip select");

endmodule

// >>> verif/host_model.sv
module host_model (
  input  wire logic       clk_sys,
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic [7:0]      addr,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  input  wire logic       rdy_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    addr = 8'h00;
    data_in = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // select frames transfer
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic oe, output logic ok);
    int n;
    @(posedge clk_sys);
    #1;
    cs_n = 1'b0;
    addr = a;
    data_in = wr ? d : ~d;
    if (wr) begin
      wr_n = 1'b0;
    end else begin
      rd_n = 1'b0;
    end
    n = 0;
    ok = 1'b0;
    while (n < 20 && !ok) begin
      @(posedge clk_sys);
      ok = (rdy_n === 1'b0);
      n++;
    end
    q = data_out;
    oe = data_oe;
    #1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    // Released bus must not keep looking like valid data
    data_in = ~data_in;
    addr = ~addr;
    n = 0;
    while (ok && n < 20 && rdy_n !== 1'b1) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20) begin
      ok = 1'b0;
    end
  endtask
endmodule

// >>> verif/host_register_port_tb_top.sv
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module host_register_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk_sys = 1'b0;
  logic         srst = 1'b1;
  logic         reset_pin_n = 1'b1;
  logic         cs_n, wr_n, rd_n, data_oe, rdy_n, int_n;
  logic [7:0]   addr, data_in, data_out;
  logic [7:0]   irq_event = 8'h00;
  logic [127:0] cfg_out;
  int           error_cnt = 0;
  int           check_count = 0;

  always #12.5 clk_sys = ~clk_sys;

  host_register_port uut (.clk_sys(clk_sys), .srst(srst), .reset_pin_n(reset_pin_n),
    .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .rdy_n(rdy_n), .int_n(int_n),
    .irq_event(irq_event), .cfg_out(cfg_out));
  host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .rdy_n(rdy_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic oe);
    logic ok;
    host.xfer(wr, a, d, q, oe, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] q, v;
    logic       oe;
    for (int i = 0; i < 16; i++) begin
      v = 8'h5A ^ 8'(i * 37);
      acc(1'b1, 8'(i), v, q, oe);
      `CHK(oe, 1'b0)
      `CHK(cfg_out[i*8 +: 8], v)
    end
    for (int i = 0; i < 16; i++) begin
      acc(1'b0, 8'(i), 8'h00, q, oe);
      `CHK(q, 8'h5A ^ 8'(i * 37))
      `CHK(oe, 1'b1)
    end
    `CHK(data_oe, 1'b0)
  endtask

  task automatic t_unmapped();
    logic [7:0] q;
    logic       oe;
    acc(1'b1, 8'h21, 8'hFF, q, oe);
    acc(1'b0, 8'h21, 8'h00, q, oe);
    `CHK(q, 8'h00)
    acc(1'b0, 8'hFF, 8'h00, q, oe);
    `CHK(q, 8'h00)
  endtask

  task automatic pulse_irq(input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    irq_event = e;
    cycles(1);
    irq_event = 8'h00;
    cycles(1);
  endtask

  task automatic t_irq();
    logic [7:0] q;
    logic       oe;
    acc(1'b1, 8'h20, 8'h01, q, oe);
    `CHK(int_n, 1'b1)
    pulse_irq(8'h02);
    `CHK(int_n, 1'b1)
    pulse_irq(8'h01);
    `CHK(int_n, 1'b0)
    cycles(3);
    `CHK(int_n, 1'b0)
    acc(1'b0, 8'h21, 8'h00, q, oe);
    `CHK(q, 8'h03)
    `CHK(int_n, 1'b1)
    acc(1'b0, 8'h21, 8'h00, q, oe);
    `CHK(q, 8'h00)
    // Event lands on the same edge as the status read: it must survive
    pulse_irq(8'h01);
    `CHK(int_n, 1'b0)
    fork
      acc(1'b0, 8'h21, 8'h00, q, oe);
      begin
        @(posedge clk_sys);
        #1;
        irq_event = 8'h04;
        cycles(1);
        irq_event = 8'h00;
      end
    join
    `CHK(q, 8'h01)
    `CHK(int_n, 1'b1)
    acc(1'b0, 8'h21, 8'h00, q, oe);
    `CHK(q, 8'h04)
  endtask

  task automatic t_reset();
    logic [7:0] q;
    logic       oe;
    acc(1'b1, 8'h03, 8'hA5, q, oe);
    @(posedge clk_sys);
    #1;
    reset_pin_n = 1'b0;
    cycles(1);
    reset_pin_n = 1'b1;
    cycles(1);
    `CHK(cfg_out, 128'h0)
    acc(1'b0, 8'h20, 8'h00, q, oe);
    `CHK(q, 8'h00)
    acc(1'b1, 8'h0F, 8'h3C, q, oe);
    `CHK(cfg_out[127:120], 8'h3C)
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    cycles(1);
    `CHK(cfg_out, 128'h0)
    `CHK(rdy_n, 1'b1)
    `CHK(int_n, 1'b1)
    t_regs();
    t_unmapped();
    t_irq();
    t_reset();
    summarize();
  end
endmodule
